// ### hw/tape_write_regs.svh
// Register offsets, reset values, codes and timing counts of the tape write path.
`ifndef TAPE_WRITE_REGS_SVH
`define TAPE_WRITE_REGS_SVH

`define SPEED_DIV_OFS 4'h0
`define DENSITY_PAIRS_OFS 4'h4
`define STATUS_OFS 4'h8

`define SPEED_DIV_RST 16'h0004
`define DENSITY_PAIRS_RST 16'h6464

`define PAIR_HI_LSB 0
`define PAIR_LO_LSB 2

`define FM_NINE_CODE 8'h13
`define FM_SEVEN_CODE 8'h0f

`define CRC_POLY 9'h03c
`define CRC_FINAL_MASK 9'h1eb

`define PRE_800 16'h0010
`define PRE_556 16'h0017
`define PRE_200 16'h0040
`define PRE_SPEED 16'h0020

`define STOP_PRE1 16'h0030
`define STOP_PRE2 16'h0100
`define STOP_GAP 16'h0018
`define STOP_POST 16'h0020
`define STOP_POST_RAW 16'h0008

`endif

// ### hw/tape_write_pkg.sv
// Types shared by the tape write path.
package tape_write_pkg;

    typedef enum logic [2:0] {
        ST_REST = 3'b000,
        ST_PRE_NORMAL = 3'b001,
        ST_PRE_LONG = 3'b010,
        ST_TRANSFER = 3'b011,
        ST_POST = 3'b100
    } fmt_state_e;

    typedef enum logic [1:0] {
        DENS_800 = 2'b00,
        DENS_556 = 2'b01,
        DENS_200 = 2'b10
    } density_e;

    typedef enum logic [1:0] {
        PH_DATA = 2'b00,
        PH_LRC = 2'b01,
        PH_GAP = 2'b10
    } write_phase_e;

    typedef struct packed {
        logic parity;
        logic [7:0] data;
    } tape_char_s;

    typedef struct packed {
        tape_char_s bus;
        logic write_clock;
    } tape_write_s;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] filt;
        fmt_state_e st;
        logic cmd_write;
        logic cmd_file_mark;
        logic cmd_erase;
        logic data_flag;
        logic [7:0] hold;
        logic upper_byte_indicator;
        write_phase_e phase;
        logic halted;
        tape_write_s tape;
        logic [8:0] crc;
        logic [8:0] longitudinal_check_char;
        logic [15:0] wpre_cnt;
        logic [15:0] wdiv_cnt;
        logic [15:0] spre_cnt;
        logic [15:0] sdiv_cnt;
        logic [15:0] delay;
        logic [15:0] speed_div;
        logic [15:0] density_pairs;
        logic ack_q;
        logic [31:0] readdata;
    } fmt_regs_s;

endpackage : tape_write_pkg

// ### hw/tape_write_path_control.sv
// Write path and transfer control of a tape formatter, with an Avalon-MM register slave.
`include "tape_write_regs.svh"

// Function
// R1: Request each character one write period ahead; host acknowledges within that period.
// R2: Acknowledge during write clears the request flag and latches the write character.
// R3: Add one parity bit per held character, odd or even per parity control.
// R4: Write bus carries data with parity, file-mark code, or cyclic check character.
// R5: Generate normal, special or seven-track file mark and clock it onto tape.
// R6: Special nine-track option writes the seven-track file-mark code instead.
// R7: Accumulate the cyclic check character from every data character written.
// R8: At record end on nine-track write cyclic check, then longitudinal check.
// R9: Write the cyclic check character as computed, zeros too, no forced parity.
// R10: Write control acts in state 3; request every character until halt.
// R11: On halt append check characters, then erase first part of the gap.
// R12: Single-head unit goes to state 4 right after the longitudinal check.
// R13: Read-after-write unit leaves state 3 only when gap detection ends it; an erase command leaves state 3 at once.
// R14: Send a byte-half indicator to split a host word into two characters.
// R15: Divide crystal clocks to a write rate set by speed and density.
// R16: Speed clock for the delay counter depends only on tape speed.
// R17: Density choice only for seven-track units; nine-track always runs 800.
// R18: Density follows host high-density line unless panel override is set.
// R19: Each seven-track unit has its own high and low density pair.
// R20: Host halt ends transfer; the request flag is then no longer raised.
// R21: Delay counter counts speed ticks to a stop chosen by state and configuration.
// R22: Read strobes reset the delay counter; reaching stop ends state 3.
// R23: Nine-track file mark octal 23 odd parity; special octal 17 even parity.
// R24: Ignore parity and density lines for nine-track units or manual panel mode.
// R25: Latch command lines on command strobe; host holds mode lines static.
// R26: Longitudinal check gives even ones per track over the whole record.
// R27: Cyclic check uses the customary nine-track shift and feedback polynomial.
module tape_write_path_control
    import tape_write_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic command_strobe,
    input wire logic cmd_write_line,
    input wire logic cmd_file_mark_line,
    input wire logic cmd_erase_line,
    input wire logic halt,
    input wire logic write_ack,
    input wire logic [7:0] write_data,
    input wire logic odd_parity_select,
    input wire logic high_density_select,
    input wire logic alt_file_mark_select,
    input wire logic panel_manual,
    input wire logic panel_odd_parity,
    input wire logic panel_density_override,
    input wire logic panel_high_density,
    input wire logic [1:0] unit_select,
    input wire logic unit_nine_track,
    input wire logic unit_read_after_write,
    input wire logic read_strobe,
    output logic data_flag,
    output logic upper_byte_indicator,
    output tape_write_s tape_write,
    output fmt_state_e fmt_state,
    output logic data_busy,
    output logic tape_motion
);

    localparam int SYN_CMD = 0;
    localparam int SYN_ACK = 1;
    localparam int SYN_HALT = 2;
    localparam int SYN_RSTB = 3;

    fmt_regs_s s;
    fmt_regs_s next_s;

    logic [3:0] agree;
    logic [3:0] rise;
    logic [3:0] pair;
    logic host_high;
    logic want_high;
    density_e density;
    logic odd;
    logic [15:0] wpre_top;
    logic wtick;
    logic stick;
    logic [7:0] ch;
    tape_char_s data_char;
    tape_char_s fm_char;
    logic [8:0] crc_step;
    logic [8:0] crc_out;
    logic [15:0] stop;
    logic stop_hit;

    always_comb begin
        // A pin change only counts once the second and third stages agree.
        agree = ~(s.sync2 ^ s.sync3);
        rise = agree & s.sync3 & ~s.filt;

        pair = s.density_pairs[{unit_select, 2'b00} +: 4]; // R19
        // Manual panel mode or a nine-track unit makes the host density and parity lines irrelevant.
        host_high = (panel_manual || unit_nine_track) ? 1'b0 : high_density_select; // R24
        want_high = panel_density_override ? panel_high_density : host_high; // R18
        if (unit_nine_track) begin
            density = DENS_800; // R17
        end else if (want_high) begin
            density = density_e'(pair[`PAIR_HI_LSB +: 2]);
        end else begin
            density = density_e'(pair[`PAIR_LO_LSB +: 2]);
        end

        if (unit_nine_track) begin
            odd = 1'b1; // R24
        end else if (panel_manual) begin
            odd = panel_odd_parity; // R24
        end else begin
            odd = odd_parity_select;
        end

        if (density == DENS_800) begin
            wpre_top = `PRE_800; // R15
        end else if (density == DENS_556) begin
            wpre_top = `PRE_556;
        end else begin
            wpre_top = `PRE_200;
        end

        // Density crystal prescale followed by the speed divider gives the write rate.
        wtick = (s.wpre_cnt >= wpre_top - 16'h0001) && (s.wdiv_cnt >= s.speed_div - 16'h0001); // R15
        // The speed clock uses one fixed prescale, so density never changes delays.
        stick = (s.spre_cnt >= `PRE_SPEED - 16'h0001) && (s.sdiv_cnt >= s.speed_div - 16'h0001); // R16

        ch = unit_nine_track ? s.hold : {2'b00, s.hold[5:0]};
        data_char.data = ch;
        data_char.parity = (^ch) ^ odd; // R3

        if (unit_nine_track && !alt_file_mark_select) begin
            fm_char.data = `FM_NINE_CODE; // R23
            fm_char.parity = ~(^fm_char.data);
        end else begin
            fm_char.data = `FM_SEVEN_CODE; // R6
            fm_char.parity = ^fm_char.data; // R23
        end

        crc_step = s.crc ^ data_char; // R7
        crc_step = {crc_step[7:0], crc_step[8]} ^ (crc_step[8] ? `CRC_POLY : 9'h000); // R27
        crc_out = {s.crc[7:0], s.crc[8]} ^ (s.crc[8] ? `CRC_POLY : 9'h000);
        crc_out = crc_out ^ `CRC_FINAL_MASK; // R27

        if (s.st == ST_PRE_NORMAL) begin
            stop = `STOP_PRE1; // R21
        end else if (s.st == ST_PRE_LONG) begin
            stop = `STOP_PRE2;
        end else if (s.st == ST_TRANSFER) begin
            stop = `STOP_GAP;
        end else if (unit_read_after_write) begin
            stop = `STOP_POST_RAW;
        end else begin
            stop = `STOP_POST;
        end
        stop_hit = stick && (s.delay >= stop - 16'h0001);
    end

    always_comb begin
        next_s = s;
        next_s.sync1 = {read_strobe, halt, write_ack, command_strobe};
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        next_s.filt = (agree & s.sync3) | (~agree & s.filt);
        next_s.tape.write_clock = 1'b0;
        next_s.ack_q = (avs_read || avs_write) && !s.ack_q;

        next_s.wpre_cnt = (s.wpre_cnt >= wpre_top - 16'h0001) ? 16'h0000 : s.wpre_cnt + 16'h0001;
        if (s.wpre_cnt >= wpre_top - 16'h0001) begin
            next_s.wdiv_cnt = wtick ? 16'h0000 : s.wdiv_cnt + 16'h0001;
        end
        next_s.spre_cnt = (s.spre_cnt >= `PRE_SPEED - 16'h0001) ? 16'h0000 : s.spre_cnt + 16'h0001;
        if (s.spre_cnt >= `PRE_SPEED - 16'h0001) begin
            next_s.sdiv_cnt = stick ? 16'h0000 : s.sdiv_cnt + 16'h0001;
        end
        if (stick) begin
            next_s.delay = s.delay + 16'h0001; // R21
        end

        // A halt that rides with the last acknowledge must still let that character reach tape.
        if (s.st == ST_TRANSFER && s.filt[SYN_HALT] && s.data_flag && !rise[SYN_ACK]) begin
            next_s.halted = 1'b1; // R20
            next_s.data_flag = 1'b0; // R20
        end
        if (rise[SYN_ACK] && s.data_flag && s.st == ST_TRANSFER && s.cmd_write) begin
            next_s.data_flag = 1'b0; // R2
            next_s.hold = write_data; // R2
        end

        case (s.st)
            ST_REST: begin
                next_s.halted = 1'b0;
                next_s.data_flag = 1'b0;
                if (rise[SYN_CMD] && (cmd_write_line || cmd_file_mark_line || cmd_erase_line)) begin
                    next_s.cmd_write = cmd_write_line; // R25
                    next_s.cmd_file_mark = cmd_file_mark_line; // R25
                    next_s.cmd_erase = cmd_erase_line; // R25
                    next_s.delay = 16'h0000;
                    next_s.st = cmd_erase_line ? ST_PRE_LONG : ST_PRE_NORMAL;
                end
            end
            ST_PRE_NORMAL, ST_PRE_LONG: begin
                if (stop_hit) begin
                    next_s.st = ST_TRANSFER;
                    next_s.delay = 16'h0000;
                    next_s.phase = PH_DATA;
                    next_s.crc = 9'h000;
                    next_s.longitudinal_check_char = 9'h000;
                    next_s.upper_byte_indicator = 1'b1;
                    // The first character is asked for a full write period early.
                    next_s.data_flag = s.cmd_write; // R1
                    // Restarting the write divider gives the host a whole period for the first answer.
                    next_s.wpre_cnt = 16'h0000; // R1
                    next_s.wdiv_cnt = 16'h0000; // R1
                end
            end
            ST_TRANSFER: begin
                if (rise[SYN_RSTB]) begin
                    next_s.delay = 16'h0000; // R22
                end
                if (!s.cmd_write && !s.cmd_file_mark) begin
                    next_s.st = ST_POST;
                    next_s.delay = 16'h0000;
                end else if (s.phase == PH_GAP) begin
                    if (stop_hit && !rise[SYN_RSTB]) begin
                        next_s.st = ST_POST; // R13
                        next_s.delay = 16'h0000;
                    end
                end else if (wtick) begin
                    next_s.tape.write_clock = 1'b1; // R5
                    if (s.phase == PH_LRC) begin
                        next_s.tape.bus = s.longitudinal_check_char; // R26
                        if (unit_read_after_write) begin
                            next_s.phase = PH_GAP; // R13
                        end else begin
                            next_s.st = ST_POST; // R12
                            next_s.delay = 16'h0000;
                        end
                    end else if (s.cmd_file_mark) begin
                        next_s.tape.bus = fm_char; // R4
                        next_s.longitudinal_check_char = s.longitudinal_check_char ^ fm_char; // R26
                        next_s.phase = PH_LRC;
                    end else if (!s.halted) begin
                        next_s.tape.bus = data_char; // R4
                        next_s.crc = crc_step; // R7
                        next_s.longitudinal_check_char = s.longitudinal_check_char ^ data_char; // R26
                        next_s.upper_byte_indicator = ~s.upper_byte_indicator; // R14
                        // A new request beats an acknowledge landing in the same cycle.
                        next_s.data_flag = !s.filt[SYN_HALT]; // R10
                        next_s.halted = s.filt[SYN_HALT]; // R20
                    end else if (unit_nine_track) begin
                        next_s.tape.bus = crc_out; // R8
                        next_s.longitudinal_check_char = s.longitudinal_check_char ^ crc_out; // R9
                        next_s.phase = PH_LRC; // R11
                    end else begin
                        next_s.tape.bus = s.longitudinal_check_char; // R11
                        if (unit_read_after_write) begin
                            next_s.phase = PH_GAP;
                        end else begin
                            next_s.st = ST_POST; // R12
                            next_s.delay = 16'h0000;
                        end
                    end
                end
            end
            ST_POST: begin
                next_s.data_flag = 1'b0;
                if (stop_hit) begin
                    next_s.st = ST_REST; // R11
                end
            end
            default: begin
                next_s.st = ST_REST;
            end
        endcase

        if ((avs_read || avs_write) && !s.ack_q && avs_read) begin
            if (avs_address == `SPEED_DIV_OFS) begin
                next_s.readdata = {16'h0000, s.speed_div};
            end else if (avs_address == `DENSITY_PAIRS_OFS) begin
                next_s.readdata = {16'h0000, s.density_pairs};
            end else if (avs_address == `STATUS_OFS) begin
                next_s.readdata = {9'h000, s.crc, s.longitudinal_check_char, s.data_flag, s.halted, s.st};
            end else begin
                next_s.readdata = 32'h0000_0000;
            end
        end
        if (avs_write && s.ack_q) begin
            if (avs_address == `SPEED_DIV_OFS) begin
                // A zero divisor would stall the clocks, so it is held at one.
                next_s.speed_div = (avs_writedata[15:0] == 16'h0000) ? 16'h0001 : avs_writedata[15:0];
            end else if (avs_address == `DENSITY_PAIRS_OFS) begin
                next_s.density_pairs = avs_writedata[15:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.speed_div <= `SPEED_DIV_RST;
            s.density_pairs <= `DENSITY_PAIRS_RST;
            s.upper_byte_indicator <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s.ack_q;
    assign avs_readdata = s.readdata;
    assign data_flag = s.data_flag;
    assign upper_byte_indicator = s.upper_byte_indicator;
    assign tape_write = s.tape;
    assign fmt_state = s.st;
    assign data_busy = (s.st == ST_TRANSFER) || (s.st == ST_POST);
    assign tape_motion = (s.st != ST_REST);

endmodule : tape_write_path_control

// ### verification/tape_write_monitor.sv
// Port checker of the tape write path.
module tape_write_monitor
    import tape_write_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic write_ack,
    input wire logic halt,
    input wire logic data_flag,
    input wire logic upper_byte_indicator,
    input wire tape_write_s tape_write,
    input wire fmt_state_e fmt_state,
    input wire logic tape_motion
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence ack_seen;
        $rose(write_ack) && data_flag;
    endsequence
    sequence flag_drop;
        ##[1:8] !data_flag;
    endsequence
    ack_clear_a: assert property (ack_seen |-> flag_drop)
        else $error("request not cleared");
    flag_state_a: assert property (data_flag |-> fmt_state == ST_TRANSFER)
        else $error("request outside transfer");
    clock_pulse_a: assert property ($rose(tape_write.write_clock) |=> !tape_write.write_clock [*8])
        else $error("write clock too long or too close");
    halt_stop_a: assert property (halt [*8] |-> !$rose(data_flag))
        else $error("request raised after halt");
    byte_half_a: assert property ($changed(upper_byte_indicator) && fmt_state == ST_TRANSFER
        && $stable(fmt_state) |-> tape_write.write_clock) else $error("byte half moved alone");
    leave_transfer_a: assert property ($changed(fmt_state) && $past(fmt_state) == ST_TRANSFER
        |-> fmt_state == ST_POST) else $error("transfer left to a wrong state");
    state_legal_a: assert property (fmt_state inside {ST_REST, ST_PRE_NORMAL, ST_PRE_LONG, ST_TRANSFER, ST_POST})
        else $error("illegal state");
    wait_answer_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not in the second cycle");
    motion_match_a: assert property (tape_motion == (fmt_state != ST_REST))
        else $error("motion does not follow state");
endmodule : tape_write_monitor

bind tape_write_path_control tape_write_monitor tape_write_monitor_inst (.clk, .rst, .avs_read, .avs_write,
    .avs_waitrequest, .write_ack, .halt, .data_flag, .upper_byte_indicator, .tape_write, .fmt_state, .tape_motion);

// ### verification/tape_host_model.sv
// Host controller model: answers character requests and ends the record with halt.
module tape_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic data_flag,
    input wire logic [7:0] base,
    input wire logic [7:0] n_chars,
    input wire logic [7:0] ack_delay,
    output logic write_ack,
    output logic [7:0] write_data,
    output logic halt
);
    timeunit 1ns;
    timeprecision 1ns;
    int sent;
    initial begin
        write_ack = 1'b0;
        halt = 1'b0;
        write_data = 8'h00;
        sent = 0;
        forever begin
            @(posedge clk);
            if (rst || !go) begin
                halt <= 1'b0;
                sent = 0;
            end else if (data_flag && !halt) begin
                repeat (int'(ack_delay)) @(posedge clk);
                write_data <= base + 8'(sent);
                repeat (4) @(posedge clk);
                write_ack <= 1'b1;
                // Halt rides with the last strobe so no further request can slip in before it.
                halt <= (sent + 1 == int'(n_chars));
                repeat (6) @(posedge clk);
                write_ack <= 1'b0;
                repeat (2) @(posedge clk);
                write_data <= ~write_data;
                sent++;
            end
        end
    end
endmodule : tape_host_model

// ### verification/tape_write_path_control_test.sv
// Self-checking bench of the tape write path with a host controller model.
module tape_write_path_control_test
    import tape_write_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, command_strobe = 1'b0, go = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'h1d36;
    logic avs_waitrequest, halt, write_ack, data_flag, upper_byte_indicator, data_busy, tape_motion;
    logic cmd_write_line = 1'b0, cmd_file_mark_line = 1'b0, cmd_erase_line = 1'b0, strobing = 1'b0;
    logic odd_parity_select = 1'b0, high_density_select = 1'b0, alt_file_mark_select = 1'b0, panel_manual = 1'b0;
    logic panel_odd_parity = 1'b0, panel_density_override = 1'b0, panel_high_density = 1'b0, read_strobe = 1'b0;
    logic unit_nine_track = 1'b0, unit_read_after_write = 1'b0;
    logic [1:0] unit_select = 2'h0;
    logic [7:0] write_data, base = 8'h00, n_chars = 8'h00, ack_delay = 8'h00;
    tape_write_s tape_write;
    fmt_state_e fmt_state;
    tape_char_s chq[$];
    int tq[$];
    int cyc = 0, errors = 0, comparisons = 0;

    always #10 clk = ~clk;

    tape_write_path_control tape_write_path_control_inst (.clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .command_strobe, .cmd_write_line, .cmd_file_mark_line,
        .cmd_erase_line, .halt, .write_ack, .write_data, .odd_parity_select, .high_density_select,
        .alt_file_mark_select, .panel_manual, .panel_odd_parity, .panel_density_override, .panel_high_density,
        .unit_select, .unit_nine_track, .unit_read_after_write, .read_strobe, .data_flag, .upper_byte_indicator,
        .tape_write, .fmt_state, .data_busy, .tape_motion);
    tape_host_model tape_host_model_inst (.clk, .rst, .go, .data_flag, .base, .n_chars, .ack_delay, .write_ack,
        .write_data, .halt);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int presc(input logic [1:0] code);
        return (code == 2'h0) ? 16 : (code == 2'h1) ? 23 : 64;
    endfunction : presc

    function automatic logic [8:0] crc_step(input logic [8:0] acc, input logic [8:0] c);
        logic [8:0] x;
        x = acc ^ c;
        return {x[7:0], x[8]} ^ (x[8] ? 9'h03c : 9'h000);
    endfunction : crc_step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
        int k;
        {avs_address, avs_writedata, avs_write, avs_read} <= {addr, wdata, wr, ~wr};
        for (k = 0; k == 0 || (avs_waitrequest !== 1'b0 && k < 50); k++) @(posedge clk);
        rd = avs_readdata;
        if (k == 50) errors++;
        {avs_write, avs_read} <= 2'b00;
        @(posedge clk);
    endtask : bus

    always @(posedge clk) begin
        cyc <= cyc + 1;
        read_strobe <= strobing & cyc[3];
        if (tape_write.write_clock === 1'b1) begin
            chq.push_back(tape_write.bus);
            tq.push_back(cyc);
        end
    end

    // Mode bits from the top: nine, raw, alt, manual, override, panel high, host high, host odd, panel odd.
    task automatic run(input logic [8:0] mode, input logic fm, input logic er, input logic [1:0] unit, input int n);
        logic nine, hi, odd;
        logic [3:0] nib;
        logic [1:0] code;
        logic [7:0] d;
        logic [8:0] acc, crc;
        int k, exp_n;
        nine = mode[8];
        odd = nine | (mode[5] ? mode[0] : mode[1]);
        hi = mode[4] ? mode[3] : (mode[2] & ~mode[5]);
        nib = 4'(16'h6464 >> (4 * unit));
        code = nine ? 2'h0 : hi ? nib[1:0] : nib[3:2];
        exp_n = er ? 0 : fm ? 2 : n + (nine ? 2 : 1);
        {unit_nine_track, unit_read_after_write, alt_file_mark_select, panel_manual, panel_density_override,
            panel_high_density, high_density_select, odd_parity_select, panel_odd_parity} <= mode;
        {unit_select, base, n_chars, ack_delay} <= {unit, 8'(rnd()), 8'(n), 8'(presc(code) - 15)};
        {cmd_write_line, cmd_file_mark_line, cmd_erase_line, command_strobe, go} <= {~fm & ~er, fm, er, 2'b11};
        chq.delete();
        tq.delete();
        repeat (6) @(posedge clk);
        {command_strobe, strobing} <= {1'b0, mode[7]};
        if (mode[7]) begin
            for (k = 0; k < 5000 && chq.size() < exp_n; k++) @(posedge clk);
            repeat (300) @(posedge clk);
            chk(32'(fmt_state), 32'(ST_TRANSFER));
            chk(32'(data_busy), 32'h1);
            strobing <= 1'b0;
        end
        for (k = 0; k < 20000 && fmt_state !== ST_REST; k++) @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        chk(32'(fmt_state), 32'(ST_REST));
        chk(32'(data_busy), 32'h0);
        chk(32'(upper_byte_indicator), (!fm && !er && n[0]) ? 32'h0 : 32'h1);
        chk(32'(chq.size()), 32'(exp_n));
        acc = 9'h000;
        crc = 9'h000;
        foreach (chq[i]) acc = acc ^ chq[i];
        chk(32'(acc), 32'h0);
        if (fm) chk(32'(chq[0]), {23'h0, 1'b0, (nine & ~mode[6]) ? 8'h13 : 8'h0f});
        for (int i = 0; i < n && !fm && !er; i++) begin
            d = base + 8'(i);
            d[7:6] = nine ? d[7:6] : 2'b00;
            chk(32'(chq[i]), 32'({odd ^ (^d), d}));
            crc = crc_step(crc, {odd ^ (^d), d});
        end
        if (nine && !fm && !er) chk(32'(chq[n]), 32'(crc_step(crc, 9'h000) ^ 9'h1eb));
        if (!fm && !er) chk(32'(tq[1] - tq[0]), 32'(presc(code)));
    endtask : run

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0004);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h6464);
        bus(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'hc, 32'hffff);
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0001);
        run(9'h100 | 9'(rnd() & 32'h6), 1'b0, 1'b0, 2'(rnd()), 2 + int'(rnd() % 4));
        run(9'h180, 1'b0, 1'b0, 2'h0, 3);
        run(9'h006, 1'b0, 1'b0, 2'h1, 3);
        run(9'h000, 1'b0, 1'b0, 2'h0, 2);
        run(9'h014, 1'b0, 1'b0, 2'h1, 2);
        run(9'h029, 1'b0, 1'b0, 2'h2, 2);
        for (int j = 0; j < 3; j++) run(9'(rnd() & 32'h3f), 1'b0, 1'b0, 2'(rnd()), 2 + int'(rnd() % 3));
        run(9'h100, 1'b1, 1'b0, 2'h0, 0);
        run(9'h140, 1'b1, 1'b0, 2'h0, 0);
        run(9'h000, 1'b1, 1'b0, 2'h0, 0);
        run(9'h100, 1'b0, 1'b1, 2'h0, 0);
        end_sim();
    end

    // The predelays and postdelays dominate the thirteen runs, so the limit leaves room for all of them twice over.
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : tape_write_path_control_test
